// ---- src/eip_pkg.sv ----
// Package: register map, field layout and timing constants of the pin detector
package eip_pkg;

  localparam logic [31:0] ADDR_PENDING = 32'hFF008500;
  localparam logic [31:0] ADDR_MASK = 32'hFF008504;
  localparam logic [31:0] ADDR_CONTROL = 32'hFF008510;
  localparam logic [31:0] ADDR_MAP_0 = 32'hFF008520;
  localparam logic [31:0] ADDR_MAP_1 = 32'hFF008524;
  localparam logic [31:0] ADDR_MAP_2 = 32'hFF008528;

  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_DETECT_LSB = 2;
  localparam int CTL_SAMPLE_BIT = 14;
  localparam int TIMER_BIT_0 = 12;
  localparam int TIMER_BIT_1 = 13;

  localparam logic [1:0] MODE_DEDICATED = 2'h0;
  localparam logic [1:0] MODE_EXPANDED = 2'h1;
  localparam logic [1:0] MODE_MIXED = 2'h2;

  localparam logic [31:0] CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] MAP_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [31:0] PENDING_RESET = 32'h00000000;
  localparam logic [31:0] PENDING_WMASK = 32'h000030FF;
  localparam logic [31:0] CONTROL_WMASK = 32'h00007FFF;
  localparam logic [31:0] MAP01_WMASK = 32'h0000FFFF;
  localparam logic [31:0] MAP2_WMASK = 32'h00FF0000;

  localparam logic [3:0] VECTOR_LOW = 4'h2;
  localparam logic [2:0] MIXED_VECTOR_LOW = 3'h2;
  localparam int SAMPLE_DIV = 2;
  localparam logic [2:0] DEBOUNCE_SAMPLES = 3'h7;

  // Register access strobe group from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } eip_req_s;

  // Handler-entry acknowledge from the core
  typedef struct packed {
    logic valid;
    logic [31:0] bits;
  } eip_ack_s;

endpackage : eip_pkg

// ---- src/eip_detect.sv ----
// External interrupt pin detector with its six-register programming interface
module eip_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Interrupt pins
  input wire logic [7:0] ext_irq_req_n,
  input wire logic nmi_req_n,
  input wire logic timer_req_0,
  input wire logic timer_req_1,
  // Register access
  input wire eip_pkg::eip_req_s bus_req,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  // Handler entry acknowledge
  input wire eip_pkg::eip_ack_s ack,
  // Requests to the core
  output logic nmi_event,
  output logic irq_request,
  output logic [7:0] irq_vector
);
  import eip_pkg::*;

  typedef enum logic [2:0] {
    EIP_DEDICATED = 3'b001,
    EIP_EXPANDED = 3'b010,
    EIP_MIXED = 3'b100
  } eip_mode_e;

  // Registers and pipeline state
  logic [31:0] irq_pending, irq_mask, irq_control;
  logic [31:0] irq_vector_map_0, irq_vector_map_1, irq_vector_map_2;
  logic [8:0] sync_a, sync_b;
  logic sample_phase;
  logic [8:0] sampled, prev_level;
  logic [2:0] stable_cnt [9];
  logic [8:0] filt;
  logic [1:0] tmr_prev;
  logic nmi_prev_f;
  logic [7:0] exp_vec;
  logic exp_valid;

  logic [31:0] next_irq_pending, next_irq_mask, next_irq_control;
  logic [31:0] next_map_0, next_map_1, next_map_2;
  logic [31:0] next_rdata;
  logic next_rvalid, next_nmi_event, next_irq_request;
  logic [7:0] next_irq_vector;
  logic [8:0] next_filt;
  logic [2:0] next_cnt [9];
  logic next_phase;
  eip_mode_e mode;
  logic [8:0] debounce_sel, level_sel;
  logic [31:0] eligible;
  logic [7:0] ded_vec;
  logic ded_hit;

  // Mode decode from the control field
  function automatic eip_mode_e decode_mode(input logic [1:0] f);
    unique case (f)
      MODE_EXPANDED: decode_mode = EIP_EXPANDED;
      MODE_MIXED: decode_mode = EIP_MIXED;
      default: decode_mode = EIP_DEDICATED;
    endcase
  endfunction : decode_mode

  // Four-bit map nibble for pending bit position
  function automatic logic [3:0] map_nibble(input int idx, input logic [31:0] m0,
                                            input logic [31:0] m1, input logic [31:0] m2);
    if (idx < 4) map_nibble = m0[idx*4 +: 4];
    else if (idx < 8) map_nibble = m1[(idx-4)*4 +: 4];
    else if (idx == TIMER_BIT_0) map_nibble = m2[19:16];
    else map_nibble = m2[23:20];
  endfunction : map_nibble

  assign mode = decode_mode(irq_control[CTL_MODE_LSB +: 2]);

  // Per input: which use debounce, which are level detected
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic expanded_pin;
      expanded_pin = (mode == EIP_EXPANDED) || (mode == EIP_MIXED && i < 5);
      debounce_sel[i] = expanded_pin || irq_control[CTL_SAMPLE_BIT];
      level_sel[i] = expanded_pin || !irq_control[CTL_DETECT_LSB + i];
    end
    debounce_sel[8] = irq_control[CTL_SAMPLE_BIT];
    level_sel[8] = 1'b0;
  end

  // Sampler and debounce filters
  always_comb begin
    next_phase = (SAMPLE_DIV == 2) ? !sample_phase : 1'b1;
    next_filt = filt;
    for (int i = 0; i < 9; i++) begin
      next_cnt[i] = stable_cnt[i];
      if (sample_phase) begin
        if (!sync_b[i] && sampled[i] == sync_b[i]) begin
          if (stable_cnt[i] != DEBOUNCE_SAMPLES) next_cnt[i] = stable_cnt[i] + 3'h1;
        end else if (!sync_b[i]) begin
          next_cnt[i] = 3'h1;
        end else begin
          next_cnt[i] = 3'h0;
        end
        if (debounce_sel[i]) next_filt[i] = !(next_cnt[i] == DEBOUNCE_SAMPLES);
        else next_filt[i] = sync_b[i];
      end
    end
  end

  // Eligible dedicated requests and their highest-priority vector
  always_comb begin
    eligible = irq_pending & irq_mask & PENDING_WMASK;
    if (mode == EIP_EXPANDED) eligible[7:0] = 8'h00;
    if (mode == EIP_MIXED) eligible[4:0] = 5'h00;
    ded_vec = 8'h00;
    ded_hit = 1'b0;
    for (int i = 0; i < 14; i++) begin
      if (eligible[i] && (!ded_hit || map_nibble(i, irq_vector_map_0, irq_vector_map_1,
          irq_vector_map_2) > ded_vec[7:4])) begin
        ded_hit = 1'b1;
        ded_vec = {map_nibble(i, irq_vector_map_0, irq_vector_map_1, irq_vector_map_2),
                   VECTOR_LOW};
      end
    end
  end

  // Register file, pending posting and outputs
  always_comb begin
    next_irq_pending = irq_pending;
    next_irq_mask = irq_mask;
    next_irq_control = irq_control;
    next_map_0 = irq_vector_map_0;
    next_map_1 = irq_vector_map_1;
    next_map_2 = irq_vector_map_2;
    next_rdata = 32'h00000000;
    next_rvalid = bus_req.rd;
    // Handler-entry clear first, then software write, then hardware sets win
    if (ack.valid) next_irq_pending = next_irq_pending & ~ack.bits;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ADDR_PENDING: next_irq_pending = bus_req.wdata & PENDING_WMASK;
        ADDR_MASK: next_irq_mask = bus_req.wdata & PENDING_WMASK;
        ADDR_CONTROL: next_irq_control = bus_req.wdata & CONTROL_WMASK;
        ADDR_MAP_0: next_map_0 = bus_req.wdata & MAP01_WMASK;
        ADDR_MAP_1: next_map_1 = bus_req.wdata & MAP01_WMASK;
        ADDR_MAP_2: next_map_2 = bus_req.wdata & MAP2_WMASK;
        default: ;
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      if (mode == EIP_DEDICATED || (mode == EIP_MIXED && i >= 5)) begin
        if (level_sel[i] && !filt[i]) next_irq_pending[i] = 1'b1;
        if (!level_sel[i] && prev_level[i] && !filt[i]) next_irq_pending[i] = 1'b1;
      end
    end
    if (timer_req_0 && !tmr_prev[0]) next_irq_pending[TIMER_BIT_0] = 1'b1;
    if (timer_req_1 && !tmr_prev[1]) next_irq_pending[TIMER_BIT_1] = 1'b1;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_PENDING: next_rdata = irq_pending;
        ADDR_MASK: next_rdata = irq_mask;
        ADDR_CONTROL: next_rdata = irq_control;
        ADDR_MAP_0: next_rdata = irq_vector_map_0;
        ADDR_MAP_1: next_rdata = irq_vector_map_1;
        ADDR_MAP_2: next_rdata = irq_vector_map_2;
        default: next_rdata = 32'h00000000;
      endcase
    end
    next_nmi_event = nmi_prev_f && !filt[8];
    // NMI outranks everything: other requests held off during its pulse
    next_irq_request = 1'b0;
    next_irq_vector = 8'h00;
    if (!next_nmi_event) begin
      if (exp_valid && irq_mask[0] && exp_vec > 8'h07) begin
        next_irq_request = 1'b1;
        next_irq_vector = exp_vec;
      end
      if (ded_hit && (!next_irq_request || ded_vec > next_irq_vector)) begin
        next_irq_request = 1'b1;
        next_irq_vector = ded_vec;
      end
    end
  end

  // Expanded vector from debounced pins
  always_comb begin
    exp_valid = 1'b0;
    exp_vec = 8'h00;
    if (mode == EIP_EXPANDED) begin
      exp_vec = ~filt[7:0];
      exp_valid = 1'b1;
    end else if (mode == EIP_MIXED) begin
      exp_vec = {~filt[4:0], MIXED_VECTOR_LOW};
      exp_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 9'h1FF;
      sync_b <= 9'h1FF;
      sample_phase <= 1'b0;
      sampled <= 9'h1FF;
      filt <= 9'h1FF;
      prev_level <= 9'h1FF;
      nmi_prev_f <= 1'b1;
      tmr_prev <= 2'h0;
      for (int i = 0; i < 9; i++) stable_cnt[i] <= 3'h0;
      irq_pending <= PENDING_RESET;
      irq_mask <= MASK_RESET;
      irq_control <= CONTROL_RESET;
      irq_vector_map_0 <= MAP_RESET;
      irq_vector_map_1 <= MAP_RESET;
      irq_vector_map_2 <= MAP_RESET;
      bus_rdata <= 32'h00000000;
      bus_rvalid <= 1'b0;
      nmi_event <= 1'b0;
      irq_request <= 1'b0;
      irq_vector <= 8'h00;
    end else begin
      sync_a <= {nmi_req_n, ext_irq_req_n};
      sync_b <= sync_a;
      sample_phase <= next_phase;
      if (sample_phase) sampled <= sync_b;
      filt <= next_filt;
      prev_level <= filt;
      nmi_prev_f <= filt[8];
      tmr_prev <= {timer_req_1, timer_req_0};
      for (int i = 0; i < 9; i++) stable_cnt[i] <= next_cnt[i];
      irq_pending <= next_irq_pending;
      irq_mask <= next_irq_mask;
      irq_control <= next_irq_control;
      irq_vector_map_0 <= next_map_0;
      irq_vector_map_1 <= next_map_1;
      irq_vector_map_2 <= next_map_2;
      bus_rdata <= next_rdata;
      bus_rvalid <= next_rvalid;
      nmi_event <= next_nmi_event;
      irq_request <= next_irq_request;
      irq_vector <= next_irq_vector;
    end
  end

endmodule : eip_detect

// ---- verification/eip_detect_monitor.sv ----
// Assertion checker for the interrupt pin detector ports
module eip_detect_monitor
  import eip_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic [7:0] ext_irq_req_n,
  input wire logic nmi_req_n,
  input wire logic timer_req_0,
  input wire logic timer_req_1,
  // Register access
  input wire eip_pkg::eip_req_s bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_rvalid,
  // Core side
  input wire eip_pkg::eip_ack_s ack,
  input wire logic nmi_event,
  input wire logic irq_request,
  input wire logic [7:0] irq_vector
);
  logic [4:0] low_cnt;
  logic dbc;
  logic [31:0] msk;
  logic mapped;
  assign mapped = bus_req.addr inside {ADDR_PENDING, ADDR_MASK, ADDR_CONTROL,
                                       ADDR_MAP_0, ADDR_MAP_1, ADDR_MAP_2};
  // Tracks pin low time, sampling choice and mask
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt <= 5'h0;
      dbc <= 1'b0;
      msk <= 32'h0;
    end else begin
      low_cnt <= nmi_req_n ? 5'h0 : ((low_cnt == 5'h1F) ? low_cnt : low_cnt + 5'h1);
      if (bus_req.wr && bus_req.addr == ADDR_CONTROL) dbc <= bus_req.wdata[CTL_SAMPLE_BIT];
      if (bus_req.wr && bus_req.addr == ADDR_MASK) msk <= bus_req.wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_answer; bus_req.rd |=> bus_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_single; !bus_req.rd |=> !bus_rvalid; endproperty
  a_rd_single: assert property (p_rd_single) else $error("answer without read");
  property p_unmapped; bus_req.rd && !mapped |=> bus_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_nmi_pulse; nmi_event |=> !nmi_event; endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi event too long");
  property p_nmi_prio; nmi_event |-> !irq_request; endproperty
  a_nmi_prio: assert property (p_nmi_prio) else $error("request beside nmi");
  property p_nmi_sync; nmi_event |-> low_cnt >= 5'h2; endproperty
  a_nmi_sync: assert property (p_nmi_sync) else $error("nmi not synchronised");
  property p_debounce; nmi_event && dbc |-> low_cnt >= 5'hC; endproperty
  a_debounce: assert property (p_debounce) else $error("debounce too short");
  property p_mask; msk == 32'h0 && $past(msk) == 32'h0 |-> !irq_request; endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
endmodule : eip_detect_monitor

bind eip_detect eip_detect_monitor i_mon (.clk(clk), .rst(rst), .ext_irq_req_n(ext_irq_req_n),
  .nmi_req_n(nmi_req_n), .timer_req_0(timer_req_0), .timer_req_1(timer_req_1),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ack(ack),
  .nmi_event(nmi_event), .irq_request(irq_request), .irq_vector(irq_vector));

// ---- verification/eip_pin_source.sv ----
// Model of the external request sources driving the pins
module eip_pin_source (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic [7:0] want_low,
  input wire logic want_nmi,
  // Pins
  output logic [7:0] ext_irq_req_n,
  output logic nmi_req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] hold = 5'h0;
  logic [8:0] held = 9'h0;
  always_ff @(posedge clk) begin
    if (({want_nmi, want_low} & ~held) != 9'h0) hold <= 5'h10;
    else if (hold != 5'h0) hold <= hold - 5'h1;
    held <= (hold > 5'h1) ? (held | {want_nmi, want_low}) : {want_nmi, want_low};
  end
  assign {nmi_req_n, ext_irq_req_n} = ~held;
endmodule : eip_pin_source

// ---- verification/testbench.sv ----
// Self-checking testbench for the interrupt pin detector
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import eip_pkg::*;
  localparam logic [31:0] ADDRS [0:5] = '{ADDR_PENDING, ADDR_MASK, ADDR_CONTROL,
                                          ADDR_MAP_0, ADDR_MAP_1, ADDR_MAP_2};
  logic clk, rst, timer_req_0, timer_req_1, want_nmi, nmi_req_n, bus_rvalid, nmi_event;
  logic irq_request;
  logic [7:0] want_low, ext_irq_req_n, irq_vector;
  logic [31:0] bus_rdata;
  eip_req_s bus_req;
  eip_ack_s ack;
  localparam int LIMIT = 20000;
  int failures, compares, n;
  int cycles = 0;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  eip_detect i_dut (.clk(clk), .rst(rst), .ext_irq_req_n(ext_irq_req_n), .nmi_req_n(nmi_req_n),
    .timer_req_0(timer_req_0), .timer_req_1(timer_req_1), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ack(ack), .nmi_event(nmi_event),
    .irq_request(irq_request), .irq_vector(irq_vector));
  eip_pin_source i_src (.clk(clk), .want_low(want_low), .want_nmi(want_nmi),
    .ext_irq_req_n(ext_irq_req_n), .nmi_req_n(nmi_req_n));
  task automatic test_done;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk(32'(bus_rvalid), 32'h1);
    chk(bus_rdata, exp);
  endtask : rd
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask : wt
  task automatic clr(input logic [31:0] b);
    @(posedge clk);
    ack <= '{valid: 1'b1, bits: b};
    @(posedge clk);
    ack <= '0;
  endtask : clr
  task automatic nmi_lat;
    @(posedge clk);
    want_nmi <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (nmi_event !== 1'b1 && n < 60);
    @(posedge clk);
    want_nmi <= 1'b0;
    wt(30);
  endtask : nmi_lat
  always @(posedge clk) cycles <= cycles + 1;
  initial begin
    rst = 1'b1;
    bus_req = '0;
    ack = '0;
    want_low = 8'h00;
    want_nmi = 1'b0;
    timer_req_0 = 1'b0;
    timer_req_1 = 1'b0;
    failures = 0;
    compares = 0;
    n = 0;
    fork
      begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (ADDRS[i]) rd(ADDRS[i], 32'h0);
        rd(32'hFF00850C, 32'h0);
        wr(ADDR_CONTROL, 32'hFFFFFFFF);
        rd(ADDR_CONTROL, CONTROL_WMASK);
        wr(ADDR_MAP_1, 32'hFFFFFFFF);
        rd(ADDR_MAP_1, MAP01_WMASK);
        wr(ADDR_MAP_2, 32'hFFFFFFFF);
        rd(ADDR_MAP_2, MAP2_WMASK);
        wr(ADDR_CONTROL, 32'h000003FC);
        wr(ADDR_MAP_0, 32'h00000005);
        wr(ADDR_MASK, 32'h000000FF);
        want_low <= 8'h01;
        wt(2);
        want_low <= 8'h00;
        wt(20);
        #1;
        chk(32'(irq_request), 32'h1);
        chk(32'(irq_vector), {24'h0, 4'h5, VECTOR_LOW});
        rd(ADDR_PENDING, 32'h1);
        wt(20);
        clr(32'h1);
        rd(ADDR_PENDING, 32'h0);
        wr(ADDR_CONTROL, 32'h0);
        want_low <= 8'h02;
        wt(20);
        rd(ADDR_PENDING, 32'h2);
        clr(32'h2);
        rd(ADDR_PENDING, 32'h2);
        wr(ADDR_PENDING, 32'h0);
        rd(ADDR_PENDING, 32'h2);
        want_low <= 8'h00;
        wt(24);
        wr(ADDR_PENDING, 32'h0);
        rd(ADDR_PENDING, 32'h0);
        nmi_lat();
        chk(32'(n <= 10), 32'h1);
        wr(ADDR_CONTROL, 32'h00004000);
        nmi_lat();
        chk(32'(n >= 13 && n < 60), 32'h1);
        wr(ADDR_CONTROL, 32'h1);
        wr(ADDR_MASK, 32'h1);
        want_low <= 8'h47;
        wt(40);
        #1;
        chk(32'(irq_request), 32'h1);
        chk(32'(irq_vector), 32'h47);
        wt(1);
        want_low <= 8'h05;
        wt(40);
        #1;
        chk(32'(irq_request), 32'h0);
        wr(ADDR_CONTROL, 32'h2);
        want_low <= 8'h09;
        wt(40);
        #1;
        chk(32'(irq_vector), 32'h4A);
        wt(1);
        want_low <= 8'h00;
        wt(40);
        wr(ADDR_CONTROL, 32'h0);
        timer_req_0 <= 1'b1;
        wt(4);
        rd(ADDR_PENDING, 32'h1000);
        timer_req_1 <= 1'b1;
        wt(4);
        rd(ADDR_PENDING, 32'h3000);
      end
      begin
        wait (cycles == LIMIT);
        failures++;
      end
    join_any
    test_done();
  end
endmodule : testbench
